// file: design/tofm_i2c_target.sv
// i2c target for the sensor setting registers and the calibration eeprom
// Overview of operation
// - answer sensor traffic only at address 0x57
// - direction bit high reads, low writes
// - eeprom answers at separate addresses 0x50/0x51, low bit picks upper half
// - eeprom holds 512 byte-addressable bytes
// - serial, user, factory sets at 0x00/0x10/0x20
// - factory calibration set never changes
// - user set starts as factory copy
`timescale 1ns/1ps
`include "tofm_regs.svh"
module tofm_i2c_target #(
  parameter logic [127:0] SERIAL_NUM  = 128'h0,  // arbitrary value
  parameter logic [127:0] FACTORY_CAL = 128'h0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe_n,
  output logic      o_init_ok
);

  localparam logic [6:0] SENS_ADDR = `TOFM_SENS_ADDR;
  localparam logic [6:0] EEP_ADDR  = `TOFM_EEP_ADDR;
  localparam logic [8:0] FACT_BASE = `TOFM_FACT_BASE;
  localparam logic [8:0] USER_BASE = `TOFM_USER_BASE;

  localparam logic [7:0][7:0] PRESCRIBED = {
    `TOFM_VAL_91, `TOFM_VAL_90, `TOFM_VAL_60, `TOFM_VAL_19,
    `TOFM_VAL_18, `TOFM_VAL_13, `TOFM_VAL_11, `TOFM_VAL_10
  };

  tofm_pkg::tofm_top_st_t st_q;
  tofm_pkg::tofm_top_st_t st_d;
  tofm_mem_if #(.AW(`TOFM_EEP_AW)) mif ();

  // maps a register index to {hit, slot}
  function automatic logic [3:0] reg_slot(input logic [7:0] idx);
    case (idx)
      `TOFM_REG_10: reg_slot = 4'h8;
      `TOFM_REG_11: reg_slot = 4'h9;
      `TOFM_REG_13: reg_slot = 4'hA;
      `TOFM_REG_18: reg_slot = 4'hB;
      `TOFM_REG_19: reg_slot = 4'hC;
      `TOFM_REG_60: reg_slot = 4'hD;
      `TOFM_REG_90: reg_slot = 4'hE;
      `TOFM_REG_91: reg_slot = 4'hF;
      default:      reg_slot = 4'h0;
    endcase
  endfunction

  // true when a write would land in the factory set
  function automatic logic in_factory(input logic [8:0] a);
    in_factory = (a >= FACT_BASE) && (a < FACT_BASE + USER_BASE);
  endfunction

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] rx_byte;
  logic [3:0] slot;
  logic [7:0] tx_byte;

  // bus events from the sampled lines
  assign scl_rise  = i_scl & ~st_q.scl;
  assign scl_fall  = ~i_scl & st_q.scl;
  assign bus_start = st_q.scl & i_scl & st_q.sda & ~i_sda;
  assign bus_stop  = st_q.scl & i_scl & ~st_q.sda & i_sda;
  assign rx_byte   = {st_q.sh[6:0], i_sda};
  assign slot      = reg_slot(st_q.ptr[7:0]);

  // byte presented on a read, from eeprom or register bank
  always_comb begin
    if (st_q.eep) begin
      tx_byte = mif.rdata;
    end else if (slot[3]) begin
      tx_byte = st_q.regs[slot[2:0]];
    end else begin
      tx_byte = `TOFM_UNMAPPED;
    end
  end

  // storage port: pending write has priority over the read pointer
  assign mif.we    = st_q.wr;
  assign mif.addr  = st_q.wr ? st_q.wa : st_q.ptr;
  assign mif.wdata = st_q.wd;

  // protocol engine
  always_comb begin
    st_d     = st_q;
    st_d.scl = i_scl;
    st_d.sda = i_sda;
    st_d.wr  = 1'b0;
    st_d.init_ok = (st_q.regs == PRESCRIBED);
    if (bus_stop) begin
      st_d.state = tofm_pkg::TOFM_IDLE;
      st_d.pull  = 1'b0;
    end else if (bus_start) begin
      st_d.state    = tofm_pkg::TOFM_ADDR;
      st_d.bitn     = 4'h0;
      st_d.pull     = 1'b0;
      st_d.host_ack = 1'b0;
    end else begin
      case (st_q.state)
        tofm_pkg::TOFM_IDLE: begin
          st_d.pull = 1'b0;
        end
        tofm_pkg::TOFM_ADDR, tofm_pkg::TOFM_INDEX, tofm_pkg::TOFM_WDATA: begin
          if (scl_rise) begin
            st_d.sh   = rx_byte;
            st_d.bitn = st_q.bitn + 4'h1;
            if (st_q.bitn == 4'h7) begin
              if (st_q.state == tofm_pkg::TOFM_ADDR) begin
                st_d.rw = rx_byte[0];
                if (rx_byte[7:1] == SENS_ADDR) begin
                  st_d.eep   = 1'b0;
                  st_d.state = tofm_pkg::TOFM_ADDR_ACK;
                end else if (rx_byte[7:2] == EEP_ADDR[6:1]) begin
                  st_d.eep    = 1'b1;
                  st_d.ptr[8] = rx_byte[1];
                  st_d.state  = tofm_pkg::TOFM_ADDR_ACK;
                end else begin
                  st_d.state = tofm_pkg::TOFM_IDLE;
                end
              end else if (st_q.state == tofm_pkg::TOFM_INDEX) begin
                st_d.ptr   = {st_q.eep & st_q.ptr[8], rx_byte};
                st_d.state = tofm_pkg::TOFM_INDEX_ACK;
              end else begin
                if (st_q.eep) begin
                  st_d.wr = ~in_factory(st_q.ptr);
                  st_d.wa = st_q.ptr;
                  st_d.wd = rx_byte;
                  st_d.ptr = st_q.ptr + 9'h001;
                end else begin
                  if (slot[3]) begin
                    st_d.regs[slot[2:0]] = rx_byte;
                  end
                  st_d.ptr = {1'b0, st_q.ptr[7:0] + 8'h01};
                end
                st_d.state = tofm_pkg::TOFM_WDATA_ACK;
              end
            end
          end
        end
        tofm_pkg::TOFM_ADDR_ACK, tofm_pkg::TOFM_INDEX_ACK, tofm_pkg::TOFM_WDATA_ACK: begin
          if (scl_fall) begin
            if (st_q.bitn == 4'h8) begin
              st_d.pull = 1'b1; // acknowledge
              st_d.bitn = 4'h9;
            end else begin
              st_d.pull = 1'b0;
              st_d.bitn = 4'h0;
              if (st_q.state == tofm_pkg::TOFM_ADDR_ACK && st_q.rw) begin
                st_d.state = tofm_pkg::TOFM_RDATA;
                st_d.sh    = tx_byte;
                st_d.pull  = ~tx_byte[7];
              end else if (st_q.state == tofm_pkg::TOFM_ADDR_ACK) begin
                st_d.state = tofm_pkg::TOFM_INDEX;
              end else begin
                st_d.state = tofm_pkg::TOFM_WDATA;
              end
            end
          end
        end
        tofm_pkg::TOFM_RDATA: begin
          if (scl_rise) begin
            if (st_q.host_ack) begin
              if (i_sda) begin
                st_d.state = tofm_pkg::TOFM_IDLE; // host ended the read
              end else begin
                st_d.bitn = 4'hA;
              end
            end else begin
              st_d.bitn = st_q.bitn + 4'h1;
              if (st_q.bitn == 4'h7) begin
                st_d.host_ack = 1'b1;
                st_d.ptr = st_q.eep ? st_q.ptr + 9'h001 : {1'b0, st_q.ptr[7:0] + 8'h01};
              end
            end
          end else if (scl_fall) begin
            if (!st_q.host_ack) begin
              st_d.sh   = {st_q.sh[6:0], 1'b0};
              st_d.pull = ~st_q.sh[6];
            end else if (st_q.bitn == 4'h8) begin
              st_d.pull = 1'b0; // release for host acknowledge
            end else if (st_q.bitn == 4'hA) begin
              st_d.host_ack = 1'b0;
              st_d.bitn     = 4'h0;
              st_d.sh       = tx_byte;
              st_d.pull     = ~tx_byte[7];
            end
          end
        end
        default: begin
          st_d.state = tofm_pkg::TOFM_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q          <= '0;
      st_q.state    <= tofm_pkg::TOFM_IDLE;
      st_q.scl      <= 1'b1;
      st_q.sda      <= 1'b1;
      st_q.regs     <= {`TOFM_NUM_REGS{`TOFM_REG_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // calibration storage
  tofm_mem #(
    .SERIAL_NUM  (SERIAL_NUM),
    .FACTORY_CAL (FACTORY_CAL)
  ) u_mem (
    .i_ref_clk (i_ref_clk),
    .port      (mif.mem)
  );

  assign o_sda_out  = 1'b0;        // open drain: only ever pulls low
  assign o_sda_oe_n = ~st_q.pull;
  assign o_init_ok  = st_q.init_ok;

endmodule // tofm_i2c_target

// file: common/tofm_regs.svh
// register offsets, bus addresses, eeprom layout and prescribed values
`ifndef TOFM_REGS_SVH
`define TOFM_REGS_SVH

// bus target addresses (7 bit)
`define TOFM_SENS_ADDR    7'h57
`define TOFM_EEP_ADDR     7'h50

// sensor setting registers
`define TOFM_REG_10       8'h10
`define TOFM_REG_11       8'h11
`define TOFM_REG_13       8'h13
`define TOFM_REG_18       8'h18
`define TOFM_REG_19       8'h19
`define TOFM_REG_60       8'h60
`define TOFM_REG_90       8'h90
`define TOFM_REG_91       8'h91
`define TOFM_NUM_REGS     8

// prescribed initialisation values
`define TOFM_VAL_10       8'h04
`define TOFM_VAL_11       8'h6E
`define TOFM_VAL_13       8'h71
`define TOFM_VAL_18       8'h22
`define TOFM_VAL_19       8'h22
`define TOFM_VAL_60       8'h01
`define TOFM_VAL_90       8'h0F
`define TOFM_VAL_91       8'hFF

// register reset value and unmapped read value
`define TOFM_REG_RST      8'h00
`define TOFM_UNMAPPED     8'h00

// eeprom layout
`define TOFM_EEP_DEPTH    512
`define TOFM_EEP_AW       9
`define TOFM_SERIAL_BASE  9'h000
`define TOFM_USER_BASE    9'h010
`define TOFM_FACT_BASE    9'h020
`define TOFM_SECT_BYTES   16

`endif

// file: common/tofm_pkg.sv
// types shared by the configuration target and its storage
package tofm_pkg;

  typedef enum logic [2:0] {
    TOFM_IDLE,
    TOFM_ADDR,
    TOFM_ADDR_ACK,
    TOFM_INDEX,
    TOFM_INDEX_ACK,
    TOFM_WDATA,
    TOFM_WDATA_ACK,
    TOFM_RDATA
  } tofm_state_t;

  typedef struct packed {
    tofm_state_t       state;
    logic              host_ack;  // read byte acknowledged phase
    logic [7:0]        sh;
    logic [3:0]        bitn;
    logic              eep;
    logic              rw;
    logic [8:0]        ptr;
    logic              pull;
    logic              scl;
    logic              sda;
    logic [7:0][7:0]   regs;
    logic              wr;
    logic [8:0]        wa;
    logic [7:0]        wd;
    logic              init_ok;
  } tofm_top_st_t;

  typedef struct packed {
    logic [7:0] rdata;
  } tofm_mem_st_t;

endpackage

// file: common/tofm_mem_if.sv
// storage port between the bus target and the eeprom array
`timescale 1ns/1ps
interface tofm_mem_if #(parameter int AW = 9);
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: design/tofm_mem.sv
// calibration eeprom array with registered read data
`timescale 1ns/1ps
`include "tofm_regs.svh"
module tofm_mem #(
  parameter int           DEPTH       = `TOFM_EEP_DEPTH,
  parameter int           AW          = `TOFM_EEP_AW,
  parameter logic [127:0] SERIAL_NUM  = 128'h0,  // arbitrary value
  parameter logic [127:0] FACTORY_CAL = 128'h0
) (
  input  wire logic i_ref_clk,
  tofm_mem_if.mem   port
);

  logic [7:0]        arr [DEPTH];
  tofm_pkg::tofm_mem_st_t st_q;
  tofm_pkg::tofm_mem_st_t st_d;

  // manufacture image: serial number, user copy of factory set, factory set
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      arr[i] = 8'hFF;
    end
    for (int i = 0; i < `TOFM_SECT_BYTES; i++) begin
      arr[int'(`TOFM_SERIAL_BASE) + i] = SERIAL_NUM[8*(15-i) +: 8];
      arr[int'(`TOFM_USER_BASE) + i]   = FACTORY_CAL[8*(15-i) +: 8];
      arr[int'(`TOFM_FACT_BASE) + i]   = FACTORY_CAL[8*(15-i) +: 8];
    end
  end

  // next read value
  always_comb begin
    st_d       = st_q;
    st_d.rdata = arr[port.addr];
  end

  // byte-addressable storage, read data registered
  always_ff @(posedge i_ref_clk) begin
    st_q <= st_d;
    if (port.we) begin
      arr[port.addr] <= port.wdata;
    end
  end

  assign port.rdata = st_q.rdata;

endmodule // tofm_mem

// file: test/tofm_host.sv
// host controller model that drives the serial clock and the data line
`timescale 1ns/1ps
module tofm_host #(
  parameter int HP = 50
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // both lines released, pulled high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // half a serial clock period; 50 reference clocks gives 400 kHz
  task automatic half();
    repeat (HP) @(posedge i_ref_clk);
  endtask
  // start or repeated start, sda falls while scl is high
  task automatic start();
    o_sda <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda <= 1'b0;
    half();
    o_scl <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // stop, sda rises while scl is high
  task automatic stop();
    o_sda <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda <= 1'b1;
    half();
  endtask
  // one bit: data set while scl low, wire sampled at the end of high
  task automatic xbit(input logic b, output logic r);
    o_sda <= b;
    half();
    o_scl <= 1'b1;
    half();
    r = i_sda;
    o_scl <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // byte out msb first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  // byte in msb first; host acknowledges unless it is the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask
endmodule // tofm_host

// file: test/tofm_props_properties.sv
// concurrent checks on the target's pins
`timescale 1ns/1ps
module tofm_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_init_ok
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // data pin and init flag timing against the serial clock and bus conditions
  a_drive_low_only: assert property (!o_sda_oe_n |-> !o_sda_out) else $error("sda driven high");
  a_pull_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl) else $error("pull begun with scl high");
  a_release_scl_low: assert property ($rose(o_sda_oe_n) |-> !i_scl) else $error("release with scl high");
  a_pull_bounded: assert property ($fell(o_sda_oe_n) |-> ##[1:1000] o_sda_oe_n) else $error("pull too long");
  a_stop_quiet: assert property (i_scl && $past(i_scl) && $rose(i_sda) |=> o_sda_oe_n [*8])
    else $error("pull after stop");
  a_start_quiet: assert property (i_scl && $past(i_scl) && $fell(i_sda) |=> o_sda_oe_n [*8])
    else $error("pull after start");
  a_setting_scl_high: assert property ($changed(o_init_ok) |-> i_scl) else $error("flag moved off a bit");
  a_bit_held_high: assert property ($rose(i_scl) |-> $stable(o_sda_oe_n) [*8]) else $error("data moved");
endmodule // tofm_props

bind tofm_i2c_target tofm_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_init_ok(o_init_ok));

// file: test/test_tofm_module_init_and_calibration_store.sv
// self-checking bench for the sensor settings and calibration storage
`timescale 1ns/1ps
`include "tofm_regs.svh"
module test_tofm_module_init_and_calibration_store;
  localparam logic [127:0] SER  = 128'h5A11_2233_4455_6677_8899_AABB_CCDD_EEF0; // arbitrary value
  localparam logic [127:0] FCAL = 128'hC3D4_0102_0304_0506_0708_090A_0B0C_0D0E;
  localparam logic [6:0]   SA   = `TOFM_SENS_ADDR;
  localparam logic [6:0]   EA   = `TOFM_EEP_ADDR;
  logic       i_ref_clk   = 1'b0;
  logic       i_rst       = 1'b1;
  logic       o_sda_out;
  logic       o_sda_oe_n;
  logic       o_init_ok;
  logic       h_scl;
  logic       h_sda;
  logic       a;
  logic [7:0] rb [4];
  logic [7:0] ridx [8] = '{8'h10, 8'h11, 8'h13, 8'h18, 8'h19, 8'h60, 8'h90, 8'h91};
  logic [7:0] rval [8] = '{8'h04, 8'h6E, 8'h71, 8'h22, 8'h22, 8'h01, 8'h0F, 8'hFF};
  int         miscompares = 0;
  int         comparisons = 0;
  wire        sda_w = h_sda & (o_sda_oe_n | o_sda_out);

  // reference clock
  always #12.5 i_ref_clk = ~i_ref_clk;

  tofm_i2c_target #(.SERIAL_NUM(SER), .FACTORY_CAL(FCAL)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_scl(h_scl), .i_sda(sda_w), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_init_ok(o_init_ok));
  tofm_host #(.HP(50)) host (.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(h_scl), .o_sda(h_sda));

  // compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // single byte write: address, index, data
  task automatic wr(input logic [6:0] dv, input logic [7:0] ix, input logic [7:0] d);
    host.start();
    host.wbyte({dv, 1'b0}, a);
    chk("wr_addr_ack", {7'h0, a}, 8'h01);
    host.wbyte(ix, a);
    host.wbyte(d, a);
    chk("wr_data_ack", {7'h0, a}, 8'h01);
    host.stop();
  endtask
  // index write, repeated start, n bytes read
  task automatic rd(input logic [6:0] dv, input logic [7:0] ix, input int n);
    host.start();
    host.wbyte({dv, 1'b0}, a);
    host.wbyte(ix, a);
    host.start();
    host.wbyte({dv, 1'b1}, a);
    chk("rd_addr_ack", {7'h0, a}, 8'h01);
    for (int k = 0; k < n; k++) host.rbyte(k == n - 1, rb[k]);
    host.stop();
  endtask
  // counts, verdict, end of run
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("ok_rst", {7'h0, o_init_ok}, 8'h00);
    for (int k = 0; k < 8; k++) wr(SA, ridx[k], rval[k]);
    chk("ok_set", {7'h0, o_init_ok}, 8'h01);
    rd(SA, 8'h10, 4);
    chk("r10", rb[0], 8'h04);
    chk("r11", rb[1], 8'h6E);
    chk("r12", rb[2], `TOFM_UNMAPPED);
    chk("r13", rb[3], 8'h71);
    host.start();
    host.wbyte({7'h56, 1'b0}, a);
    chk("foreign_ack", {7'h0, a}, 8'h00);
    host.stop();
    wr(SA, 8'h11, 8'h00);
    chk("ok_off", {7'h0, o_init_ok}, 8'h00);
    wr(SA, 8'h11, 8'h6E);
    chk("ok_back", {7'h0, o_init_ok}, 8'h01);
    rd(EA, 8'h00, 1);
    chk("serial", rb[0], SER[127:120]);
    rd(EA, 8'h20, 2);
    chk("fact0", rb[0], FCAL[127:120]);
    chk("fact1", rb[1], FCAL[119:112]);
    rd(EA, 8'h10, 2);
    chk("user0", rb[0], FCAL[127:120]);
    chk("user1", rb[1], FCAL[119:112]);
    wr(EA, 8'h20, 8'h55);
    rd(EA, 8'h20, 1);
    chk("fact_kept", rb[0], FCAL[127:120]);
    wr(EA, 8'h10, 8'hA5);
    rd(EA, 8'h10, 1);
    chk("user_new", rb[0], 8'hA5);
    wr(7'h51, 8'hFF, 8'h3C);
    rd(7'h51, 8'hFF, 1);
    chk("top_byte", rb[0], 8'h3C);
    rd(EA, 8'hFF, 1);
    chk("free_byte", rb[0], 8'hFF);
    print_verdict();
  end

  // watchdog well past the expected run of about 80k cycles
  initial begin
    repeat (130000) @(posedge i_ref_clk);
    miscompares++;
    print_verdict();
  end
endmodule // test_tofm_module_init_and_calibration_store
